// File: pkg/tsw_pkg.sv
// Overview of operation
// - Loops always run over the opposite interface through a spare timeslot.
// - The PCM timeslot used by a loop can float so the PCM side stays quiet.
// - Tristate field low impedance gives a transparent loop, high impedance a silent one.
// - Same pointer in the downstream memory drives the line output from upstream data.
// - Pointer MSB one selects upstream data memory, zero selects downstream data memory.
// - Address MSB one selects upstream connection memory, zero the downstream one.
// - Command 0110 0000 stores the pointer low nibble into the addressed tristate field.
// - Each tristate bit drives one PCM bit pair; one drives, zero floats.
// - Command 0111 plus code writes connection memory; code 0110 switches bits 3..2.
// - Code 0011 switches a 32 kbit/s subchannel at PCM bits 7..4.
// - Code 0111 switches a 16 kbit/s subchannel at PCM bits 7..6.
// - Code 0001 switches the whole eight bit timeslot.
// - Port position 01 puts 16 kbit/s at bits 5..4 and 32 kbit/s at 3..0.
// - Port position 10 puts 16 kbit/s at bits 3..2 and 32 kbit/s at 7..4.
// - Line position is fixed per port; code picks only bandwidth on the line side.
// - One sub-timeslot per line timeslot; PCM timeslots may mix subchannels freely.
package tsw_pkg;

  // ------------------------------------------------------------------
  // Host write selectors and command encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] TSW_SEL_POINTER  = 2'h0;
  localparam logic [1:0] TSW_SEL_ADDRESS  = 2'h1;
  localparam logic [1:0] TSW_SEL_COMMAND  = 2'h2;
  localparam logic [1:0] TSW_SEL_POSITION = 2'h3;
  localparam logic [7:0] TSW_CMD_TRISTATE = 8'h60;
  localparam logic [3:0] TSW_CMD_CM_HI    = 4'h7;
  localparam logic [7:0] TSW_REG_RESET    = 8'h00;
  localparam logic [3:0] TSW_TRI_RESET    = 4'h0;
  localparam int         TSW_SLOTS        = 128;
  localparam int         TSW_FIFO_DEPTH   = 8;
  localparam int         TSW_SEL_MSB      = 7;

  // ------------------------------------------------------------------
  // Connection codes and subchannel widths
  // ------------------------------------------------------------------
  localparam logic [3:0] TSW_CODE_NONE  = 4'h0;
  localparam logic [3:0] TSW_CODE_64    = 4'h1;
  localparam logic [3:0] TSW_CODE_32_LO = 4'h2;
  localparam logic [3:0] TSW_CODE_32_HI = 4'h3;
  localparam logic [3:0] TSW_CODE_16_B0 = 4'h4;
  localparam logic [3:0] TSW_CODE_16_B4 = 4'h5;
  localparam logic [3:0] TSW_CODE_16_B2 = 4'h6;
  localparam logic [3:0] TSW_CODE_16_B6 = 4'h7;
  localparam logic [3:0] TSW_W8 = 4'h8;
  localparam logic [3:0] TSW_W4 = 4'h4;
  localparam logic [3:0] TSW_W2 = 4'h2;
  localparam logic [3:0] TSW_W0 = 4'h0;

  typedef struct packed {
    logic [7:0] ptr;
    logic [3:0] code;
  } tsw_cm_entry_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] drive;
  } tsw_line_word_t;

  typedef enum logic [1:0] {
    TSW_IDLE = 2'b01,
    TSW_EXEC = 2'b10
  } tsw_state_t;

  // Bandwidth of a connection code in bits.
  function automatic logic [3:0] tsw_code_width(input logic [3:0] code);
    case (code)
      TSW_CODE_64:                   tsw_code_width = TSW_W8;
      TSW_CODE_32_LO, TSW_CODE_32_HI: tsw_code_width = TSW_W4;
      TSW_CODE_16_B0, TSW_CODE_16_B2,
      TSW_CODE_16_B4, TSW_CODE_16_B6: tsw_code_width = TSW_W2;
      default:                       tsw_code_width = TSW_W0;
    endcase
  endfunction

  // Lowest PCM bit that a connection code occupies.
  function automatic logic [2:0] tsw_pcm_lsb(input logic [3:0] code);
    case (code)
      TSW_CODE_32_HI: tsw_pcm_lsb = 3'h4;
      TSW_CODE_16_B2: tsw_pcm_lsb = 3'h2;
      TSW_CODE_16_B4: tsw_pcm_lsb = 3'h4;
      TSW_CODE_16_B6: tsw_pcm_lsb = 3'h6;
      default:        tsw_pcm_lsb = 3'h0;
    endcase
  endfunction

  // Lowest line bit, fixed per port by its two-bit position setting.
  function automatic logic [2:0] tsw_line_lsb(input logic [1:0] pos, input logic [3:0] w);
    case (pos)
      2'h3:    tsw_line_lsb = (w == TSW_W2) ? 3'h0 : 3'h0;
      2'h1:    tsw_line_lsb = (w == TSW_W2) ? 3'h4 : 3'h0;
      2'h2:    tsw_line_lsb = (w == TSW_W2) ? 3'h2 : 3'h4;
      default: tsw_line_lsb = (w == TSW_W2) ? 3'h6 : 3'h4;
    endcase
    if (w == TSW_W8) tsw_line_lsb = 3'h0;
  endfunction

  // Mask of the low bits covered by a width.
  function automatic logic [7:0] tsw_mask(input logic [3:0] w);
    case (w)
      TSW_W8:  tsw_mask = 8'hff;
      TSW_W4:  tsw_mask = 8'h0f;
      TSW_W2:  tsw_mask = 8'h03;
      default: tsw_mask = 8'h00;
    endcase
  endfunction

endpackage

// File: hdl/tsw_fifo.sv
`timescale 1ns/1ns
module tsw_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             s_valid_i,
  output logic                  s_ready_o,
  input  wire logic [WIDTH-1:0] s_data_i,
  output logic                  m_valid_o,
  input  wire logic             m_ready_i,
  output logic [WIDTH-1:0]      m_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // Ready and valid come from registers so the flags never glitch.
  assign push      = s_valid_i && s_ready_o;
  assign pop       = m_valid_o && m_ready_i;
  assign m_data_o  = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Storage and pointers.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= s_data_i;
        wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Occupancy and the honest full and empty flags.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count     <= '0;
      s_ready_o <= 1'b1;
      m_valid_o <= 1'b0;
    end else begin
      count     <= next_count;
      s_ready_o <= (next_count != (AW+1)'(DEPTH));
      m_valid_o <= (next_count != '0);
    end
  end

  property p_fifo_full;
    @(posedge clock_i) disable iff (rst_i) !s_ready_o |-> count == (AW+1)'(DEPTH);
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("fifo refused while not full");
endmodule

// File: hdl/tsw_switch.sv
`timescale 1ns/1ns
module tsw_switch
  import tsw_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       host_wr_i,
  input  wire logic [1:0] host_sel_i,
  input  wire logic [7:0] host_data_i,
  output logic            cmd_busy_o,
  output logic [7:0]      line_position_o,
  input  wire logic       line_up_valid_i,
  input  wire logic [6:0] line_up_slot_i,
  input  wire logic [7:0] line_up_data_i,
  input  wire logic       pcm_dn_valid_i,
  input  wire logic [6:0] pcm_dn_slot_i,
  input  wire logic [7:0] pcm_dn_data_i,
  input  wire logic       pcm_tx_req_i,
  input  wire logic [6:0] pcm_tx_slot_i,
  output logic            pcm_tx_valid_o,
  output logic [7:0]      pcm_tx_data_o,
  output logic [7:0]      pcm_tx_drive_o,
  input  wire logic       line_dn_req_i,
  input  wire logic [6:0] line_dn_slot_i,
  output logic            line_dn_req_ready_o,
  output logic            line_dn_valid_o,
  input  wire logic       line_dn_ready_i,
  output logic [7:0]      line_dn_data_o,
  output logic [7:0]      line_dn_drive_o
);

  // ------------------------------------------------------------------
  // Host registers
  // ------------------------------------------------------------------
  logic [7:0]    pointer_data_reg;
  logic [7:0]    target_address_reg;
  logic [7:0]    memory_command_reg;
  logic [7:0]    line_subchannel_position_reg;
  tsw_state_t    state;
  tsw_state_t    next_state;

  // Memories: connection memories per direction, data memories, tristate fields.
  tsw_cm_entry_t up_connection_memory [TSW_SLOTS];
  tsw_cm_entry_t dn_connection_memory [TSW_SLOTS];
  logic [7:0]    up_frame_data_memory [TSW_SLOTS];
  logic [7:0]    dn_frame_data_memory [TSW_SLOTS];
  logic [3:0]    tristate_field       [TSW_SLOTS];

  logic          exec_cm;
  logic          exec_tri;
  tsw_cm_entry_t up_entry;
  tsw_cm_entry_t dn_entry;
  logic [3:0]    up_width;
  logic [3:0]    dn_width;
  logic [1:0]    up_pos;
  logic [1:0]    dn_pos;
  logic [7:0]    up_mask;
  logic [7:0]    up_field;
  logic [7:0]    dn_source;
  tsw_line_word_t dn_word;
  tsw_line_word_t fifo_out;

  // All checks here share one clock.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Loaded values are held until the command lands, so write pointer and address first.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pointer_data_reg             <= TSW_REG_RESET;
      target_address_reg           <= TSW_REG_RESET;
      memory_command_reg           <= TSW_REG_RESET;
      line_subchannel_position_reg <= TSW_REG_RESET;
    end else if (host_wr_i) begin
      case (host_sel_i)
        TSW_SEL_POINTER:  pointer_data_reg             <= host_data_i;
        TSW_SEL_ADDRESS:  target_address_reg           <= host_data_i;
        TSW_SEL_COMMAND:  memory_command_reg           <= host_data_i;
        TSW_SEL_POSITION: line_subchannel_position_reg <= host_data_i;
        default:          pointer_data_reg             <= pointer_data_reg;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------
  // A command write arms one execute cycle; pointer or address writes never act alone.
  always_comb begin
    next_state = state;
    case (state)
      TSW_IDLE: begin
        if (host_wr_i && host_sel_i == TSW_SEL_COMMAND) begin
          next_state = TSW_EXEC;
        end
      end
      TSW_EXEC: next_state = TSW_IDLE;
      default:  next_state = TSW_IDLE;
    endcase
  end

  // Busy marks the execute cycle.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state      <= TSW_IDLE;
      cmd_busy_o <= 1'b0;
    end else begin
      state      <= next_state;
      cmd_busy_o <= (next_state == TSW_EXEC);
    end
  end

  assign exec_cm  = (state == TSW_EXEC) && (memory_command_reg[7:4] == TSW_CMD_CM_HI);
  assign exec_tri = (state == TSW_EXEC) && (memory_command_reg == TSW_CMD_TRISTATE);

  // ------------------------------------------------------------------
  // Connection memory and tristate field updates
  // ------------------------------------------------------------------
  // Codes reset to unassigned so no line output drives before programming.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < TSW_SLOTS; i++) begin
        up_connection_memory[i] <= '0;
        dn_connection_memory[i] <= '0;
      end
    end else if (exec_cm) begin
      if (target_address_reg[TSW_SEL_MSB]) begin
        up_connection_memory[target_address_reg[6:0]] <=
          '{ptr: pointer_data_reg, code: memory_command_reg[3:0]};
      end else begin
        dn_connection_memory[target_address_reg[6:0]] <=
          '{ptr: pointer_data_reg, code: memory_command_reg[3:0]};
      end
    end
  end

  // Tristate fields reset to floating, so every transmit slot starts quiet.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < TSW_SLOTS; i++) begin
        tristate_field[i] <= TSW_TRI_RESET;
      end
    end else if (exec_tri) begin
      tristate_field[target_address_reg[6:0]] <= pointer_data_reg[3:0];
    end
  end

  // Position copy, one cycle late.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      line_position_o <= TSW_REG_RESET;
    end else begin
      line_position_o <= line_subchannel_position_reg;
    end
  end

  // ------------------------------------------------------------------
  // Upstream path: line input into upstream data memory
  // ------------------------------------------------------------------
  // Port number sits in the two low address bits; the position pair follows the port.
  assign up_entry = up_connection_memory[line_up_slot_i];
  assign up_width = tsw_code_width(up_entry.code);
  assign up_pos   = line_subchannel_position_reg[2*line_up_slot_i[1:0] +: 2];
  assign up_mask  = tsw_mask(up_width) << tsw_pcm_lsb(up_entry.code);
  assign up_field = ((line_up_data_i >> tsw_line_lsb(up_pos, up_width)) &
                     tsw_mask(up_width)) << tsw_pcm_lsb(up_entry.code);

  // Only the occupied bit pairs change, so other subchannels in the slot survive.
  always_ff @(posedge clock_i) begin
    if (line_up_valid_i && up_entry.ptr[TSW_SEL_MSB] && up_width != TSW_W0) begin
      up_frame_data_memory[up_entry.ptr[6:0]] <=
        (up_frame_data_memory[up_entry.ptr[6:0]] & ~up_mask) | up_field;
    end
  end

  // Downstream PCM input is stored whole.
  always_ff @(posedge clock_i) begin
    if (pcm_dn_valid_i) begin
      dn_frame_data_memory[pcm_dn_slot_i] <= pcm_dn_data_i;
    end
  end

  // ------------------------------------------------------------------
  // PCM transmit with per-pair tristate control
  // ------------------------------------------------------------------
  // A loop's spare slot floats unless the host opened its pairs for a transparent loop.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pcm_tx_valid_o <= 1'b0;
      pcm_tx_data_o  <= 8'h00;
      pcm_tx_drive_o <= 8'h00;
    end else begin
      pcm_tx_valid_o <= pcm_tx_req_i;
      if (pcm_tx_req_i) begin
        pcm_tx_data_o <= up_frame_data_memory[pcm_tx_slot_i];
        for (int k = 0; k < 4; k++) begin
          pcm_tx_drive_o[2*k +: 2] <= {2{tristate_field[pcm_tx_slot_i][k]}};
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Downstream path: line output through the FIFO
  // ------------------------------------------------------------------
  // Line bits follow the port setting.
  assign dn_entry  = dn_connection_memory[line_dn_slot_i];
  assign dn_width  = tsw_code_width(dn_entry.code);
  assign dn_pos    = line_subchannel_position_reg[2*line_dn_slot_i[1:0] +: 2];
  assign dn_source = dn_entry.ptr[TSW_SEL_MSB] ? up_frame_data_memory[dn_entry.ptr[6:0]] :
                     dn_frame_data_memory[dn_entry.ptr[6:0]];
  assign dn_word.drive = tsw_mask(dn_width) << tsw_line_lsb(dn_pos, dn_width);
  assign dn_word.data  = ((dn_source >> tsw_pcm_lsb(dn_entry.code)) &
                          tsw_mask(dn_width)) << tsw_line_lsb(dn_pos, dn_width);

  // The FIFO absorbs a stalled line reader; a full FIFO refuses new slot requests.
  tsw_fifo #(
    .WIDTH ($bits(tsw_line_word_t)),
    .DEPTH (TSW_FIFO_DEPTH)
  ) u_fifo (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .s_valid_i (line_dn_req_i),
    .s_ready_o (line_dn_req_ready_o),
    .s_data_i  (dn_word),
    .m_valid_o (line_dn_valid_o),
    .m_ready_i (line_dn_ready_i),
    .m_data_o  (fifo_out)
  );

  // Queued word onto the line outputs.
  assign line_dn_data_o  = fifo_out.data;
  assign line_dn_drive_o = fifo_out.drive;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_cmd_exec;
    host_wr_i && host_sel_i == TSW_SEL_COMMAND && state == TSW_IDLE
      |=> state == TSW_EXEC ##1 state == TSW_IDLE;
  endproperty
  a_cmd_exec: assert property (p_cmd_exec) else $error("command did not execute once");

  property p_tri_store;
    exec_tri |=> tristate_field[$past(target_address_reg[6:0])] == $past(pointer_data_reg[3:0]);
  endproperty
  a_tri_store: assert property (p_tri_store) else $error("tristate field not stored");

  property p_cm_up;
    exec_cm && target_address_reg[7]
      |=> up_connection_memory[$past(target_address_reg[6:0])].ptr == $past(pointer_data_reg);
  endproperty
  a_cm_up: assert property (p_cm_up) else $error("upstream memory not written");

  property p_cm_dn;
    exec_cm && !target_address_reg[7]
      |=> dn_connection_memory[$past(target_address_reg[6:0])].code ==
          $past(memory_command_reg[3:0]);
  endproperty
  a_cm_dn: assert property (p_cm_dn) else $error("downstream memory not written");

  property p_tx_pairs;
    pcm_tx_valid_o |-> pcm_tx_drive_o[1] == pcm_tx_drive_o[0] &&
      pcm_tx_drive_o[3] == pcm_tx_drive_o[2] && pcm_tx_drive_o[5] == pcm_tx_drive_o[4] &&
      pcm_tx_drive_o[7] == pcm_tx_drive_o[6];
  endproperty
  a_tx_pairs: assert property (p_tx_pairs) else $error("drive not paired");

  property p_dn_full_slot;
    line_dn_req_i && dn_entry.code == TSW_CODE_64 && dn_entry.ptr[7]
      |-> dn_word.data == up_frame_data_memory[dn_entry.ptr[6:0]] && dn_word.drive == 8'hff;
  endproperty
  a_dn_full_slot: assert property (p_dn_full_slot) else $error("loop output wrong");

  property p_dn_width;
    line_dn_req_i |-> $countones(dn_word.drive) == int'(dn_width);
  endproperty
  a_dn_width: assert property (p_dn_width) else $error("line width wrong");

  property p_dn_sel;
    line_dn_req_i && dn_entry.code == TSW_CODE_16_B6 && dn_pos == 2'h1
      |-> dn_word.drive == 8'h30 && dn_word.data[5:4] == dn_source[7:6];
  endproperty
  a_dn_sel: assert property (p_dn_sel) else $error("subchannel misplaced");

  property p_up_merge;
    line_up_valid_i && up_entry.ptr[7] && up_entry.code == TSW_CODE_64
      |=> up_frame_data_memory[$past(up_entry.ptr[6:0])] == $past(line_up_data_i);
  endproperty
  a_up_merge: assert property (p_up_merge) else $error("upstream data not stored");

  property p_tx_float;
    pcm_tx_req_i &&
      tristate_field[pcm_tx_slot_i] == TSW_TRI_RESET
      |=> pcm_tx_drive_o == 8'h00;
  endproperty
  a_tx_float: assert property (p_tx_float) else $error("slot not floated");

  property p_tx_open;
    pcm_tx_req_i &&
      tristate_field[pcm_tx_slot_i] == 4'hf
      |=> pcm_tx_drive_o == 8'hff &&
          pcm_tx_data_o == $past(up_frame_data_memory[pcm_tx_slot_i]);
  endproperty
  a_tx_open: assert property (p_tx_open) else $error("loop not sent");

  property p_dn_clear;
    line_dn_req_i
      |-> (dn_word.data & ~dn_word.drive) == 8'h00;
  endproperty
  a_dn_clear: assert property (p_dn_clear) else $error("stray line data");

  property p_dn_none;
    line_dn_req_i &&
      dn_entry.code == TSW_CODE_NONE
      |-> dn_word.drive == 8'h00;
  endproperty
  a_dn_none: assert property (p_dn_none) else $error("idle slot drives");

  property p_exec_busy;
    exec_cm || exec_tri
      |-> cmd_busy_o;
  endproperty
  a_exec_busy: assert property (p_exec_busy) else $error("no busy");

  // Main scenarios.
  c_tri_cmd:  cover property (exec_tri);

  c_loop_up:  cover property (line_up_valid_i && up_entry.ptr[7] && up_width != TSW_W0);

  c_fifo_full: cover property (line_dn_req_i && !line_dn_req_ready_o);

  c_loop_open: cover property (pcm_tx_valid_o && pcm_tx_drive_o == 8'hff);

  c_dn_sub:   cover property (line_dn_req_i && line_dn_req_ready_o && dn_width == TSW_W2);
endmodule

// File: tb/tsw_line_sink.sv
`timescale 1ns/1ns
// ----------------------------------------
// Line side receiver
// ----------------------------------------
module tsw_line_sink (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       hold_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] drive_i,
  output logic            ready_o,
  output logic            got_o,
  output logic [7:0]      got_data_o,
  output logic [7:0]      got_drive_o
);
  // A held port refuses words, so the queue in front of it has to back up.
  assign ready_o = !hold_i && !rst_i;
  // Each taken word is shown for one cycle only; a line port keeps nothing.
  always_ff @(posedge clock_i) begin
    got_o       <= valid_i && ready_o && !rst_i;
    got_data_o  <= data_i;
    got_drive_o <= drive_i;
  end
endmodule

// File: tb/tsw_switch_tb_top.sv
`timescale 1ns/1ns
module tsw_switch_tb_top
  import tsw_pkg::*;
;
  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  logic          clock_i, rst_i, wr, hold, lu_v, pd_v, tx_rq, dn_rq;
  logic          busy, tx_v, rq_rdy, dn_v, dn_rdy, got;
  logic [1:0]    sel;
  logic [6:0]    lu_s, pd_s, tx_s, dn_s;
  logic [7:0]    hd, lu_d, pd_d, pos_o, tx_d, tx_dr, dn_d, dn_dr, g_d, g_dr, pos, r;
  logic [7:0]    up_dm [128];
  logic [7:0]    dn_dm [128];
  logic [3:0]    trf [128];
  tsw_cm_entry_t cmu [128];
  tsw_cm_entry_t cmdn [128];
  logic [15:0]   q [$];
  logic [15:0]   lf = 16'hf63c;
  logic [23:0]   tbl [13] = '{24'h84a074, 24'h84a376, 24'h84a275, 24'h84a477, 24'h85a673,
                              24'h85a772, 24'h058460, 24'h0b1d73, 24'h102e77, 24'h103176,
                              24'h0b2b71, 24'h102872, 24'h843074};
  logic [6:0]    dls [8] = '{7'h1d, 7'h2e, 7'h31, 7'h2b, 7'h28, 7'h30, 7'h1b, 7'h35};
  int            bad_count = 0;
  int            cmp_count = 0;

  tsw_switch dut_u (.clock_i(clock_i), .rst_i(rst_i), .host_wr_i(wr), .host_sel_i(sel),
    .host_data_i(hd), .cmd_busy_o(busy), .line_position_o(pos_o), .line_up_valid_i(lu_v),
    .line_up_slot_i(lu_s), .line_up_data_i(lu_d), .pcm_dn_valid_i(pd_v),
    .pcm_dn_slot_i(pd_s), .pcm_dn_data_i(pd_d), .pcm_tx_req_i(tx_rq), .pcm_tx_slot_i(tx_s),
    .pcm_tx_valid_o(tx_v), .pcm_tx_data_o(tx_d), .pcm_tx_drive_o(tx_dr),
    .line_dn_req_i(dn_rq), .line_dn_slot_i(dn_s), .line_dn_req_ready_o(rq_rdy),
    .line_dn_valid_o(dn_v), .line_dn_ready_i(dn_rdy), .line_dn_data_o(dn_d),
    .line_dn_drive_o(dn_dr));

  tsw_line_sink sink_u (.clock_i(clock_i), .rst_i(rst_i), .hold_i(hold), .valid_i(dn_v),
    .data_i(dn_d), .drive_i(dn_dr), .ready_o(dn_rdy), .got_o(got), .got_data_o(g_d),
    .got_drive_o(g_dr));

  // ----------------------------------------
  // Expectation functions
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    rnd = lf[7:0];
  endfunction
  function automatic logic [7:0] wm(input logic [3:0] c);
    case (c)
      4'h1:                   wm = 8'hff;
      4'h2, 4'h3:             wm = 8'h0f;
      4'h4, 4'h5, 4'h6, 4'h7: wm = 8'h03;
      default:                wm = 8'h00;
    endcase
  endfunction
  function automatic int pl(input logic [3:0] c);
    case (c)
      4'h3, 4'h5: pl = 4;
      4'h6:       pl = 2;
      4'h7:       pl = 6;
      default:    pl = 0;
    endcase
  endfunction
  // The line position depends on the port setting and the code's width only.
  function automatic int ll(input logic [1:0] p, input logic [3:0] c);
    if (c == 4'h1 || p == 2'h3) ll = 0;
    else if (p == 2'h1) ll = (wm(c) == 8'h03) ? 4 : 0;
    else if (p == 2'h2) ll = (wm(c) == 8'h03) ? 2 : 4;
    else ll = (wm(c) == 8'h03) ? 6 : 4;
  endfunction
  function automatic logic [7:0] drv(input logic [3:0] t);
    drv = {{2{t[3]}}, {2{t[2]}}, {2{t[1]}}, {2{t[0]}}};
  endfunction
  function automatic logic [15:0] exp_dn(input logic [6:0] s);
    logic [7:0] b;
    int         l;
    l = ll(pos[2*s[1:0] +: 2], cmdn[s].code);
    b = cmdn[s].ptr[7] ? up_dm[cmdn[s].ptr[6:0]] : dn_dm[cmdn[s].ptr[6:0]];
    b = ((b >> pl(cmdn[s].code)) & wm(cmdn[s].code)) << l;
    exp_dn = {b, wm(cmdn[s].code) << l};
  endfunction

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic hw(input logic [1:0] s, input logic [7:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    sel <= s;
    hd <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  // Pointer and address go first, so the command finds them loaded.
  task automatic cm(input logic [7:0] p, input logic [7:0] a, input logic [7:0] c);
    hw(TSW_SEL_POINTER, p);
    hw(TSW_SEL_ADDRESS, a);
    hw(TSW_SEL_COMMAND, c);
    #1;
    if (c == TSW_CMD_TRISTATE || c[7:4] == TSW_CMD_CM_HI) chk(busy, 1'b1, "busy");
    @(posedge clock_i);
    if (c == TSW_CMD_TRISTATE) trf[a[6:0]] = p[3:0];
    else if (c[7:4] == TSW_CMD_CM_HI && a[7]) cmu[a[6:0]] = {p, c[3:0]};
    else if (c[7:4] == TSW_CMD_CM_HI) cmdn[a[6:0]] = {p, c[3:0]};
  endtask
  task automatic lu(input logic [6:0] s, input logic [7:0] d);
    logic [7:0] m;
    m = wm(cmu[s].code) << pl(cmu[s].code);
    @(posedge clock_i);
    lu_v <= 1'b1;
    lu_s <= s;
    lu_d <= d;
    @(posedge clock_i);
    lu_v <= 1'b0;
    if (cmu[s].ptr[7]) up_dm[cmu[s].ptr[6:0]] = (up_dm[cmu[s].ptr[6:0]] & ~m) |
      (((d >> ll(pos[2*s[1:0] +: 2], cmu[s].code)) & wm(cmu[s].code)) << pl(cmu[s].code));
  endtask
  task automatic pd(input logic [6:0] s, input logic [7:0] d);
    @(posedge clock_i);
    pd_v <= 1'b1;
    pd_s <= s;
    pd_d <= d;
    @(posedge clock_i);
    pd_v <= 1'b0;
    dn_dm[s] = d;
  endtask
  task automatic tx(input logic [6:0] s);
    @(posedge clock_i);
    tx_rq <= 1'b1;
    tx_s <= s;
    @(posedge clock_i);
    tx_rq <= 1'b0;
    #1;
    chk(tx_v, 1'b1, "tx valid");
    chk({tx_d, tx_dr}, {up_dm[s], drv(trf[s])}, "tx word");
  endtask
  task automatic rq(input logic [6:0] s);
    int n;
    n = 0;
    @(posedge clock_i);
    dn_rq <= 1'b1;
    dn_s <= s;
    do begin
      @(posedge clock_i);
      n++;
    end while (rq_rdy !== 1'b1 && n < 50);
    dn_rq <= 1'b0;
    if (n < 50) q.push_back(exp_dn(s));
    else chk(1'b0, 1'b1, "request stuck");
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and output monitor
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // The whole run needs about three hundred cycles.
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    results();
  end
  // Every word leaving the line port is compared in arrival order.
  always @(posedge clock_i) begin
    if (got === 1'b1 && q.size() == 0) chk(1'b1, 1'b0, "extra word");
    else if (got === 1'b1) chk({g_d, g_dr}, q.pop_front(), "line word");
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_i, wr, hold, lu_v, pd_v, tx_rq, dn_rq} = 7'h40;
    {sel, hd, lu_s, lu_d, pd_s, pd_d, tx_s, dn_s} = '0;
    pos = 8'h00;
    foreach (trf[i]) begin
      trf[i] = 4'h0;
      cmu[i] = '0;
      cmdn[i] = '0;
    end
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk({busy, tx_v, rq_rdy, dn_v, pos_o}, 12'h200, "reset");
    hw(TSW_SEL_POSITION, 8'h93);
    pos = 8'h93;
    @(posedge clock_i);
    #1;
    chk(pos_o, 8'h93, "position");
    // A line loop through spare PCM slot 0, silent and then transparent.
    cm(8'h80, 8'h94, 8'h71);
    cm(8'h80, 8'h1b, 8'h71);
    cm(8'h00, 8'h80, 8'h60);
    lu(7'h14, rnd());
    tx(7'h00);
    cm(8'h0f, 8'h80, 8'h60);
    tx(7'h00);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      cm({r[7:4], (i == 0) ? 4'h5 : r[3:0]}, 8'h80, 8'h60);
      tx(7'h00);
    end
    cm(8'hff, 8'h80, 8'h61);
    tx(7'h00);
    // Mixed subchannels into PCM slots 4 and 5, plus downstream links.
    foreach (tbl[i]) cm(tbl[i][23:16], tbl[i][15:8], tbl[i][7:0]);
    for (int i = 0; i < 6; i++) lu(tbl[i][14:8], rnd());
    pd(7'h0b, rnd());
    pd(7'h10, rnd());
    tx(7'h04);
    tx(7'h05);
    // Fill the queue with the port held, then drain with random stalls.
    @(posedge clock_i);
    hold <= 1'b1;
    foreach (dls[i]) rq(dls[i]);
    repeat (2) @(posedge clock_i);
    #1;
    chk(rq_rdy, 1'b0, "queue full");
    fork
      rq(7'h1d);
      begin
        repeat (4) @(posedge clock_i);
        hold <= 1'b0;
      end
    join
    repeat (40) begin
      @(posedge clock_i);
      hold <= rnd() > 8'h9f;
    end
    @(posedge clock_i);
    hold <= 1'b0;
    repeat (30) @(posedge clock_i);
    #1;
    chk({q.size() == 0, dn_v}, 2'h2, "drained");
    results();
  end
endmodule
